// ---- sead_regs.vh ----
`ifndef SEAD_REGS_VH
`define SEAD_REGS_VH

// Address byte field positions
`define SEAD_TYPE_MSB    7
`define SEAD_TYPE_LSB    4
`define SEAD_ADDR_MSB    3
`define SEAD_ADDR_LSB    1
`define SEAD_RW_BIT      0

// Type identifiers
`define SEAD_TYPE_MEM    4'ha
`define SEAD_TYPE_PAGE   4'h6

// Bits in one address byte
`define SEAD_BYTE_BITS   4'h8

// Reset value of the shift register
`define SEAD_SHIFT_RST   8'h00

`endif

// ---- sead_edge.v ----
// Registers the bus pins and reports edges and bus conditions
module sead_edge (
  ref_clk,
  rst_n,
  scl_in,
  sda_in,
  scl_rise,
  scl_fall,
  start_det,
  stop_det,
  sda_q
);
  input  wire ref_clk;
  input  wire rst_n;
  input  wire scl_in;
  input  wire sda_in;
  output wire scl_rise;
  output wire scl_fall;
  output wire start_det;
  output wire stop_det;
  output reg  sda_q;

  reg scl_q;
  reg scl_p_q;
  reg sda_p_q;

  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      scl_q   <= 1'b1;
      sda_q   <= 1'b1;
      scl_p_q <= 1'b1;
      sda_p_q <= 1'b1;
    end else begin
      scl_q   <= scl_in;
      sda_q   <= sda_in;
      scl_p_q <= scl_q;
      sda_p_q <= sda_q;
    end
  end

  assign scl_rise  = scl_q & ~scl_p_q;
  assign scl_fall  = ~scl_q & scl_p_q;
  // Start: data falls while clock stays high
  assign start_det = scl_q & scl_p_q & sda_p_q & ~sda_q;
  assign stop_det  = scl_q & scl_p_q & ~sda_p_q & sda_q;
endmodule // sead_edge

// ---- sead_decoder.v ----
// What this block does
// - After each Start, first byte is 7-bit address plus read/write bit.
// - Split byte: type bits 7-4, address bits 3-1, read/write bit 0.
// - Type 1010 selects the memory read and write path.
// - Type 0110 selects the page-address function.
// - Address bits must equal the three strap inputs to match.
// - Bit 0 set means read, clear means write.
// - On full match, acknowledge during the ninth clock.
// - On mismatch, leave not-acknowledge and return to standby.
// - Hold data low through the whole high phase of ninth clock.
// - Detect Start as data falling while clock high; idle until then.
`include "sead_regs.vh"

module sead_decoder (
  ref_clk,
  rst_n,
  scl_in,
  sda_in,
  sda_out,
  sda_oe,
  strap_addr_bit2,
  strap_addr_bit1,
  strap_addr_bit0,
  sel_mem,
  sel_page,
  sel_read,
  addr_valid,
  standby
);
  input  wire ref_clk;
  input  wire rst_n;
  input  wire scl_in;
  input  wire sda_in;
  output reg  sda_out;
  output reg  sda_oe;
  input  wire strap_addr_bit2;
  input  wire strap_addr_bit1;
  input  wire strap_addr_bit0;
  output reg  sel_mem;
  output reg  sel_page;
  output reg  sel_read;
  output reg  addr_valid;
  output reg  standby;

  // Address-phase states
  localparam [1:0] ST_IDLE  = 2'd0;
  localparam [1:0] ST_SHIFT = 2'd1;
  localparam [1:0] ST_ACK   = 2'd2;
  localparam [1:0] ST_SEL   = 2'd3;

  // Pin edge and bus condition strobes
  wire       scl_rise;
  wire       scl_fall;
  wire       start_det;
  wire       stop_det;
  wire       sda_s;

  // State, bit counter and answer of the address phase
  reg  [1:0] state_q;
  reg  [1:0] state_d;
  reg  [7:0] shift_q;
  reg  [7:0] shift_d;
  reg  [3:0] cnt_q;
  reg  [3:0] cnt_d;
  reg        ack_q;
  reg        ack_d;
  reg        ack_seen_q;
  reg        ack_seen_d;

  // Next values of the selection outputs
  reg        sel_mem_d;
  reg        sel_page_d;
  reg        sel_read_d;
  reg        valid_d;

  // Decoded fields
  wire [3:0] type_id;
  wire [2:0] addr_rx;
  wire [2:0] strap;
  wire [2:0] addr_eq;
  wire       is_mem;
  wire       is_page;
  wire       hit;
  genvar     g;

  // Registered pins and edge strobes
  sead_edge u_edge (
    .ref_clk   (ref_clk),
    .rst_n     (rst_n),
    .scl_in    (scl_in),
    .sda_in    (sda_in),
    .scl_rise  (scl_rise),
    .scl_fall  (scl_fall),
    .start_det (start_det),
    .stop_det  (stop_det),
    .sda_q     (sda_s)
  );

  // Fields of the captured address byte
  assign type_id = shift_q[`SEAD_TYPE_MSB:`SEAD_TYPE_LSB];
  assign addr_rx = shift_q[`SEAD_ADDR_MSB:`SEAD_ADDR_LSB];
  assign strap   = {strap_addr_bit2, strap_addr_bit1, strap_addr_bit0};
  assign is_mem  = (type_id == `SEAD_TYPE_MEM);
  assign is_page = (type_id == `SEAD_TYPE_PAGE);

  // One comparator per strap pin; all three must agree for a match
  generate
    for (g = 0; g < 3; g = g + 1) begin : g_strap
      assign addr_eq[g] = (addr_rx[g] == strap[g]);
    end
  endgenerate

  assign hit     = (is_mem | is_page) & (&addr_eq);

  // Next-state logic; Start and Stop override the current state
  always @* begin
    state_d    = state_q;
    shift_d    = shift_q;
    cnt_d      = cnt_q;
    ack_d      = ack_q;
    ack_seen_d = ack_seen_q;
    sel_mem_d  = sel_mem;
    sel_page_d = sel_page;
    sel_read_d = sel_read;
    valid_d    = addr_valid;
    if (start_det) begin
      // Every Start, repeated or not, restarts address capture
      state_d    = ST_SHIFT;
      shift_d    = `SEAD_SHIFT_RST;
      cnt_d      = 4'h0;
      ack_d      = 1'b0;
      ack_seen_d = 1'b0;
      valid_d    = 1'b0;
    end else if (stop_det) begin
      // Stop ends any transfer and sends the device back to standby
      state_d = ST_IDLE;
      ack_d   = 1'b0;
      valid_d = 1'b0;
    end else begin
      case (state_q)
        ST_IDLE: begin
          // Standby: bus traffic is ignored until a Start
          ack_d = 1'b0;
        end
        ST_SHIFT: begin
          if (scl_rise) begin
            // Sample data on the registered clock rise
            shift_d = {shift_q[6:0], sda_s};
            // Count received bits up to a full byte
            cnt_d   = cnt_q + 4'h1;
          end else if (scl_fall && cnt_q == `SEAD_BYTE_BITS) begin
            // Drive the answer from the falling edge before the ninth clock
            state_d    = ST_ACK;
            ack_d      = hit;
            ack_seen_d = 1'b0;
            // Selection outputs follow the byte even on a mismatch
            sel_mem_d  = is_mem;
            sel_page_d = is_page;
            sel_read_d = shift_q[`SEAD_RW_BIT];
          end
        end
        ST_ACK: begin
          if (scl_rise) begin
            // Ninth clock high phase has begun
            ack_seen_d = 1'b1;
          end else if (scl_fall && ack_seen_q) begin
            // Release only after the ninth clock high phase ends
            ack_d = 1'b0;
            if (ack_q) begin
              state_d = ST_SEL;
              valid_d = 1'b1;
            end else begin
              state_d = ST_IDLE;
            end
          end
        end
        ST_SEL: begin
          // Selected: later bytes belong to the path chosen by sel_mem or sel_page
          ack_d = 1'b0;
        end
        default: begin
          // Unused code: recover to standby
          state_d = ST_IDLE;
          ack_d   = 1'b0;
        end
      endcase
    end
  end

  // Every output leaves from a flip-flop
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      // Standby with the data line released
      state_q    <= ST_IDLE;
      shift_q    <= `SEAD_SHIFT_RST;
      cnt_q      <= 4'h0;
      ack_q      <= 1'b0;
      ack_seen_q <= 1'b0;
      sda_out    <= 1'b0;
      sda_oe     <= 1'b0;
      sel_mem    <= 1'b0;
      sel_page   <= 1'b0;
      sel_read   <= 1'b0;
      addr_valid <= 1'b0;
      standby    <= 1'b1;
    end else begin
      state_q    <= state_d;
      shift_q    <= shift_d;
      cnt_q      <= cnt_d;
      ack_q      <= ack_d;
      ack_seen_q <= ack_seen_d;
      // Open drain: the value is always low, the enable does the work
      sda_out    <= 1'b0;
      sda_oe     <= ack_d;
      sel_mem    <= sel_mem_d;
      sel_page   <= sel_page_d;
      sel_read   <= sel_read_d;
      addr_valid <= valid_d;
      standby    <= (state_d == ST_IDLE);
    end
  end
endmodule // sead_decoder

// ---- sead_asserts.sv ----
module sead_asserts (
  input wire ref_clk,
  input wire rst_n,
  input wire scl_in,
  input wire sda_out,
  input wire sda_oe,
  input wire sel_mem,
  input wire sel_page,
  input wire addr_valid,
  input wire standby
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  ack_awake_a: assert property (sda_oe |-> !standby && !sda_out) else $error("oe idle");
  ack_high_a: assert property (sda_oe && scl_in |=> sda_oe) else $error("oe cut");
  ack_end_a: assert property ($rose(sda_oe) |-> ##[1:40] !sda_oe) else $error("oe stuck");
  ack_low_a: assert property ($rose(sda_oe) |-> !scl_in) else $error("oe late");
  valid_type_a: assert property (addr_valid |-> sel_mem != sel_page) else $error("no type");
  valid_awake_a: assert property (addr_valid |-> !standby) else $error("valid idle");
  start_wake_a: assert property ($fell(standby) |-> scl_in) else $error("wake");
  valid_rise_a: assert property ($rose(addr_valid) |-> !scl_in) else $error("valid late");
  cover property ($rose(addr_valid) && sel_mem);
  cover property ($rose(addr_valid) && sel_page);
  cover property ($rose(standby));
endmodule // sead_asserts

bind sead_decoder sead_asserts chk_u (.ref_clk, .rst_n, .scl_in, .sda_out, .sda_oe, .sel_mem, .sel_page,
  .addr_valid, .standby);

// ---- sead_master.sv ----
module sead_master (
  input  wire  ref_clk,
  input  wire  sda_bus,
  output logic scl,
  output logic sda_pull
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    scl = 1'b1;
    sda_pull = 1'b0;
  end
  task automatic wt(input int n);
    repeat (n) @(posedge ref_clk);
  endtask
  // Data moves only while the clock is low
  task automatic bit_x(input logic b, output logic s);
    sda_pull <= !b;
    wt(4);
    scl <= 1'b1;
    wt(4);
    s = sda_bus;
    wt(4);
    scl <= 1'b0;
    wt(6);
  endtask
  task automatic start;
    sda_pull <= 1'b0;
    wt(4);
    scl <= 1'b1;
    wt(4);
    sda_pull <= 1'b1;
    wt(4);
    scl <= 1'b0;
    wt(4);
  endtask
  task automatic stop;
    sda_pull <= 1'b1;
    wt(4);
    scl <= 1'b1;
    wt(4);
    sda_pull <= 1'b0;
    wt(8);
  endtask
  task automatic send(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) bit_x(b[i], s);
    bit_x(1'b1, s);
    ack = !s;
  endtask
endmodule // sead_master

// ---- tb.sv ----
`include "sead_regs.vh"
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic       ref_clk;
  logic       rst_n;
  logic [2:0] strap;
  logic       ack;
  int         err_count;
  int         checks;
  int         cyc;
  wire        scl, pull, sda_out, sda_oe, sel_mem, sel_page, sel_read, addr_valid, standby;
  // Pull-up on the data wire
  wire        sda = !pull && (!sda_oe || sda_out);
  sead_decoder dut_u (.ref_clk, .rst_n, .scl_in(scl), .sda_in(sda), .sda_out, .sda_oe,
    .strap_addr_bit2(strap[2]), .strap_addr_bit1(strap[1]), .strap_addr_bit0(strap[0]),
    .sel_mem, .sel_page, .sel_read, .addr_valid, .standby);
  sead_master m_u (.ref_clk, .sda_bus(sda), .scl, .sda_pull(pull));
  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end
  task automatic chk(input string n, input logic e, input logic v);
    checks++;
    if (v !== e) begin
      err_count++;
      $display("Error %s expected %b seen %b", n, e, v);
    end
  endtask
  task automatic wrap_up;
    $display("checks %0d errors %0d", checks, err_count);
    if (err_count == 0 && checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      wrap_up();
    end
  end
  task automatic t_idle;
    chk("standby", 1'b1, standby);
    m_u.send(8'ha0, ack);
    chk("ack", 1'b0, ack);
    $display("t_idle done");
  endtask
  task automatic t_decode;
    logic [3:0] ty;
    logic       hit;
    for (int i = 0; i < 8; i++) begin
      ty = (i % 3 == 0) ? `SEAD_TYPE_MEM : (i % 3 == 1) ? `SEAD_TYPE_PAGE : 4'h3;
      hit = ty != 4'h3;
      strap <= i[2:0];
      m_u.start();
      m_u.send({ty, i[2:0], i[0]}, ack);
      chk("ack", hit, ack);
      chk("addr_valid", hit, addr_valid);
      chk("standby", !hit, standby);
      if (hit) begin
        chk("sel_mem", ty == `SEAD_TYPE_MEM, sel_mem);
        chk("sel_page", ty == `SEAD_TYPE_PAGE, sel_page);
        chk("sel_read", i[0], sel_read);
      end
      m_u.stop();
    end
    $display("t_decode done");
  endtask
  task automatic t_ignore;
    strap <= 3'h5;
    m_u.start();
    m_u.send(8'ha8, ack);
    chk("ack", 1'b0, ack);
    chk("standby", 1'b1, standby);
    m_u.send(8'haa, ack);
    chk("ack", 1'b0, ack);
    chk("standby", 1'b1, standby);
    m_u.start();
    m_u.send(8'hab, ack);
    chk("ack", 1'b1, ack);
    chk("sel_read", 1'b1, sel_read);
    m_u.start();
    m_u.send(8'h6a, ack);
    chk("ack", 1'b1, ack);
    chk("sel_page", 1'b1, sel_page);
    chk("sel_mem", 1'b0, sel_mem);
    chk("sel_read", 1'b0, sel_read);
    m_u.stop();
    $display("t_ignore done");
  endtask
  initial begin
    rst_n = 1'b0;
    strap = 3'h0;
    repeat (2) @(posedge ref_clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge ref_clk);
    t_idle();
    t_decode();
    t_ignore();
    wrap_up();
  end
endmodule // tb
